// *** adcsc_control.sv ***
// Purpose: Start sequencing, timing and power control of the ADC
// Assumes: All inputs synchronous to clk; analog core is external
// Notes: Register bus is the SFR port: address, write strobe, read strobe
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_defines.svh"
module adcsc_control
	import adcsc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic timer_overflow,
	input wire logic convert_start_pin_n,
	input wire logic irq_vector_ack,
	input wire logic dma_block_done,
	input wire logic [3:0] dma_channel_id,
	output logic dma_start,
	output logic busy,
	output logic track_hold,
	output logic [3:0] mux_channel,
	output logic adc_clk_en,
	output logic ref_power_on,
	output logic core_power_on,
	output logic result_valid,
	output logic [3:0] result_channel
);
	adcsc_state_s s_q, s_d;

	function automatic logic [4:0] acq_clks(input logic [1:0] code);
		case (code)
			2'h0: acq_clks = `ADCSC_ACQ_CLKS_0;
			2'h1: acq_clks = `ADCSC_ACQ_CLKS_1;
			2'h2: acq_clks = `ADCSC_ACQ_CLKS_2;
			default: acq_clks = `ADCSC_ACQ_CLKS_3;
		endcase
	endfunction

	function automatic logic [2:0] div_last(input logic [1:0] code);
		case (code)
			2'h0: div_last = `ADCSC_DIV_LAST_1;
			2'h1: div_last = `ADCSC_DIV_LAST_2;
			2'h2: div_last = `ADCSC_DIV_LAST_4;
			default: div_last = `ADCSC_DIV_LAST_8;
		endcase
	endfunction

	logic [1:0] pm;
	logic [1:0] ck;
	logic tick;
	logic wr_chan;
	logic wr_time;
	logic start_req;
	logic t2_fire;
	logic ext_fire;
	logic end_conv;
	logic [7:0] chan_next;

	always_comb
	begin
		s_d = s_q;
		pm = s_q.time_ctrl[`ADCSC_BIT_PM_HI:`ADCSC_BIT_PM_LO];
		ck = s_q.time_ctrl[`ADCSC_BIT_CK_HI:`ADCSC_BIT_CK_LO];
		wr_chan = sfr_wr && (sfr_addr == `ADCSC_ADDR_CHAN_CTRL);
		wr_time = sfr_wr && (sfr_addr == `ADCSC_ADDR_TIME_CTRL);
		// ADC clock enable pulse, one master cycle per ADC clock
		// Compare, not equality: a divider rewrite mid-cycle must not skip a wrap
		tick = (s_q.div_cnt >= div_last(ck));
		if (s_q.st == ADCSC_IDLE || tick)
			s_d.div_cnt = 3'h0;
		else
			s_d.div_cnt = s_q.div_cnt + 3'h1;
		// Timer trigger counts overflows in pairs
		t2_fire = 1'b0;
		if (s_q.time_ctrl[`ADCSC_BIT_T2] && timer_overflow && s_q.st == ADCSC_IDLE)
		begin
			s_d.t2_seen = !s_q.t2_seen;
			t2_fire = s_q.t2_seen;
		end
		if (!s_q.time_ctrl[`ADCSC_BIT_T2])
			s_d.t2_seen = 1'b0;
		s_d.ext_prev = convert_start_pin_n;
		// Falling edge: pulse width is the source's duty
		ext_fire = s_q.time_ctrl[`ADCSC_BIT_EXT] && s_q.ext_prev && !convert_start_pin_n;
		chan_next = s_q.chan_ctrl;
		if (wr_chan)
		begin
			chan_next[`ADCSC_BIT_DMA:`ADCSC_BIT_CH_LO] = sfr_wdata[`ADCSC_BIT_DMA:`ADCSC_BIT_CH_LO];
			chan_next[`ADCSC_BIT_DONE] = s_q.chan_ctrl[`ADCSC_BIT_DONE] & sfr_wdata[`ADCSC_BIT_DONE];
		end
		if (wr_time)
			s_d.time_ctrl = sfr_wdata;
		start_req = (s_q.chan_ctrl[`ADCSC_BIT_SINGLE] || s_q.chan_ctrl[`ADCSC_BIT_CONT]
			|| t2_fire || ext_fire) && !s_q.chan_ctrl[`ADCSC_BIT_DMA] && pm != `ADCSC_PM_OFF;
		end_conv = 1'b0;
		s_d.conv_go = 1'b0;
		s_d.result_valid = 1'b0;
		case (s_q.st)
			ADCSC_IDLE:
			begin
				// Requests only honoured here, so a running cycle never restarts
				if (start_req)
				begin
					s_d.st = ADCSC_ACQ;
					s_d.conv_ch = s_q.chan_ctrl[`ADCSC_BIT_CH_HI:`ADCSC_BIT_CH_LO];
					s_d.conv_dma = 1'b0;
					s_d.step_cnt = 5'h00;
				end
				else if (s_q.dma_start && dma_channel_id != `ADCSC_CH_STOP)
				begin
					s_d.st = ADCSC_ACQ;
					s_d.conv_ch = dma_channel_id;
					s_d.conv_dma = 1'b1;
					s_d.step_cnt = 5'h00;
				end
			end
			ADCSC_ACQ:
			begin
				if (tick)
				begin
					if (s_q.step_cnt == acq_clks(s_q.time_ctrl[`ADCSC_BIT_AQ_HI:`ADCSC_BIT_AQ_LO]) - 5'h01)
					begin
						s_d.st = ADCSC_CONV;
						s_d.conv_go = 1'b1;
						s_d.step_cnt = 5'h00;
					end
					else
						s_d.step_cnt = s_q.step_cnt + 5'h01;
				end
			end
			ADCSC_CONV:
			begin
				if (tick)
				begin
					if (s_q.step_cnt == `ADCSC_CONV_CLKS - 5'h01)
					begin
						s_d.st = ADCSC_IDLE;
						end_conv = 1'b1;
						s_d.result_valid = 1'b1;
						s_d.result_ch = s_q.conv_ch;
					end
					else
						s_d.step_cnt = s_q.step_cnt + 5'h01;
				end
			end
			default: s_d.st = ADCSC_IDLE;
		endcase
		// A fresh software start in the same cycle wins over the self-clear
		if (end_conv && !s_q.conv_dma && s_q.chan_ctrl[`ADCSC_BIT_SINGLE]
			&& !(wr_chan && sfr_wdata[`ADCSC_BIT_SINGLE]))
			chan_next[`ADCSC_BIT_SINGLE] = 1'b0;
		// Set beats clear: completion wins over vector ack and writes
		if (irq_vector_ack)
			chan_next[`ADCSC_BIT_DONE] = 1'b0;
		if ((end_conv && !s_q.conv_dma) || dma_block_done)
			chan_next[`ADCSC_BIT_DONE] = 1'b1;
		if (dma_block_done && !(wr_chan && sfr_wdata[`ADCSC_BIT_DMA]))
			chan_next[`ADCSC_BIT_DMA] = 1'b0;
		s_d.chan_ctrl = chan_next;
		s_d.dma_prev = s_q.chan_ctrl[`ADCSC_BIT_DMA];
		if (s_q.chan_ctrl[`ADCSC_BIT_DMA] && !s_q.dma_prev)
			s_d.dma_start = 1'b1;
		else if (!s_q.chan_ctrl[`ADCSC_BIT_DMA] || (s_q.dma_start && dma_channel_id == `ADCSC_CH_STOP))
			s_d.dma_start = 1'b0;
		s_d.busy = (s_d.st != ADCSC_IDLE);
		s_d.track = (s_d.st == ADCSC_ACQ);
		s_d.mux_ch = s_d.conv_ch;
		s_d.adc_clk_en = (s_d.st != ADCSC_IDLE);
		// Power: reference stays up in idle power-down and standby; core on only while busy in both
		case (pm)
			`ADCSC_PM_OFF:
			begin
				s_d.ref_pwr = 1'b0;
				s_d.core_pwr = 1'b0;
			end
			`ADCSC_PM_NORMAL:
			begin
				s_d.ref_pwr = 1'b1;
				s_d.core_pwr = 1'b1;
			end
			`ADCSC_PM_OFF_IDLE:
			begin
				s_d.ref_pwr = 1'b1;
				s_d.core_pwr = s_d.busy;
			end
			default:
			begin
				s_d.ref_pwr = 1'b1;
				s_d.core_pwr = s_d.busy;
			end
		endcase
		if (sfr_rd && sfr_addr == `ADCSC_ADDR_CHAN_CTRL)
			s_d.rdata = s_q.chan_ctrl;
		else if (sfr_rd && sfr_addr == `ADCSC_ADDR_TIME_CTRL)
			s_d.rdata = s_q.time_ctrl;
		else
			s_d.rdata = 8'h00;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_q <= '0;
			s_q.chan_ctrl <= `ADCSC_RST_CHAN_CTRL;
			s_q.time_ctrl <= `ADCSC_RST_TIME_CTRL;
			s_q.ext_prev <= 1'b1;
			s_q.st <= ADCSC_IDLE;
		end
		else if (ce)
			s_q <= s_d;
	end

	assign sfr_rdata = s_q.rdata;
	assign dma_start = s_q.dma_start;
	assign busy = s_q.busy;
	assign track_hold = s_q.track;
	assign mux_channel = s_q.mux_ch;
	assign adc_clk_en = s_q.adc_clk_en;
	assign ref_power_on = s_q.ref_pwr;
	assign core_power_on = s_q.core_pwr;
	assign result_valid = s_q.result_valid;
	assign result_channel = s_q.result_ch;

	property p_busy_result;
		@(posedge clk) disable iff (srst)
		ce && s_q.result_valid |-> !s_q.busy;
	endproperty
	a_busy_result: assert property (p_busy_result) else $error("busy after result");

	property p_done_set;
		@(posedge clk) disable iff (srst)
		ce && s_q.result_valid && !s_q.conv_dma |-> s_q.chan_ctrl[`ADCSC_BIT_DONE];
	endproperty
	a_done_set: assert property (p_done_set) else $error("done flag not set");

	property p_single_clear;
		@(posedge clk) disable iff (srst)
		ce && s_q.result_valid && !s_q.conv_dma && !$past(s_q.chan_ctrl[`ADCSC_BIT_CONT])
			&& !$past(wr_chan) |-> !s_q.chan_ctrl[`ADCSC_BIT_SINGLE];
	endproperty
	a_single_clear: assert property (p_single_clear) else $error("single bit kept");

	property p_off_power;
		@(posedge clk) disable iff (srst)
		ce && $past(ce) && $past(pm) == `ADCSC_PM_OFF |-> !s_q.ref_pwr && !s_q.core_pwr;
	endproperty
	a_off_power: assert property (p_off_power) else $error("power on in off mode");

	property p_no_restart;
		@(posedge clk) disable iff (srst)
		ce && s_q.st == ADCSC_CONV && $past(s_q.st) == ADCSC_CONV |-> $stable(s_q.conv_ch);
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("channel changed mid cycle");

	property p_div1_tick;
		@(posedge clk) disable iff (srst)
		ck == 2'h0 |-> tick;
	endproperty
	a_div1_tick: assert property (p_div1_tick) else $error("divide by one lost ticks");

	property p_mux_busy;
		@(posedge clk) disable iff (srst)
		s_q.busy |-> s_q.mux_ch == s_q.conv_ch;
	endproperty
	a_mux_busy: assert property (p_mux_busy) else $error("mux channel mismatch");

	property p_vector_clear;
		@(posedge clk) disable iff (srst)
		ce && irq_vector_ack && !end_conv && !dma_block_done |=> !s_q.chan_ctrl[`ADCSC_BIT_DONE];
	endproperty
	a_vector_clear: assert property (p_vector_clear) else $error("flag kept after vector");

	property p_off_idle;
		@(posedge clk) disable iff (srst)
		ce && s_q.st == ADCSC_IDLE && pm == `ADCSC_PM_OFF && !s_q.dma_start
			|=> s_q.st == ADCSC_IDLE;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("start while powered down");

	property p_acq_to_conv;
		@(posedge clk) disable iff (srst)
		ce && s_q.st == ADCSC_ACQ && tick
			&& s_q.step_cnt == acq_clks(s_q.time_ctrl[`ADCSC_BIT_AQ_HI:`ADCSC_BIT_AQ_LO]) - 5'h01
			|=> s_q.st == ADCSC_CONV && !s_q.track;
	endproperty
	a_acq_to_conv: assert property (p_acq_to_conv) else $error("acquisition overran");

	property p_t2_first;
		@(posedge clk) disable iff (srst)
		ce && s_q.st == ADCSC_IDLE && timer_overflow && s_q.time_ctrl[`ADCSC_BIT_T2]
			&& !s_q.t2_seen && !s_q.chan_ctrl[`ADCSC_BIT_SINGLE] && !s_q.chan_ctrl[`ADCSC_BIT_CONT]
			&& !ext_fire && !s_q.dma_start |=> s_q.st == ADCSC_IDLE;
	endproperty
	a_t2_first: assert property (p_t2_first) else $error("first overflow started");

	property p_pin_start;
		@(posedge clk) disable iff (srst)
		ce && s_q.st == ADCSC_IDLE && ext_fire && !s_q.chan_ctrl[`ADCSC_BIT_DMA]
			&& pm != `ADCSC_PM_OFF |=> s_q.st == ADCSC_ACQ && s_q.busy;
	endproperty
	a_pin_start: assert property (p_pin_start) else $error("pin edge ignored");

	property p_cont_restart;
		@(posedge clk) disable iff (srst)
		ce && s_q.result_valid && s_q.chan_ctrl[`ADCSC_BIT_CONT] && !s_q.chan_ctrl[`ADCSC_BIT_DMA]
			&& pm != `ADCSC_PM_OFF |=> s_q.busy;
	endproperty
	a_cont_restart: assert property (p_cont_restart) else $error("no continuous restart");

	property p_dma_stop;
		@(posedge clk) disable iff (srst)
		ce && s_q.st == ADCSC_IDLE && s_q.dma_start && dma_channel_id == `ADCSC_CH_STOP
			&& !start_req |=> !s_q.busy && !s_q.dma_start;
	endproperty
	a_dma_stop: assert property (p_dma_stop) else $error("stop marker converted");
endmodule
`default_nettype wire

// *** adcsc_core_model.sv ***
// Purpose: Far-side model: start pin source and interrupt vector ack
// Assumes: Requests from the bench arrive as one-cycle pulses
// Notes: Pin held low three cycles, 300 ns at 10 MHz
`timescale 1ns/1ps
`default_nettype none
module adcsc_core_model (
	input wire logic clk,
	input wire logic ext_go,
	input wire logic ack_go,
	output logic pin_n,
	output var logic irq_vector_ack = 1'b0
);
	logic [1:0] low_cnt = 2'h0;
	always_ff @(posedge clk)
	begin
		if (ext_go)
			low_cnt <= 2'h3;
		else if (low_cnt != 2'h0)
			low_cnt <= low_cnt - 2'h1;
		irq_vector_ack <= ack_go;
	end
	assign pin_n = (low_cnt == 2'h0);
endmodule
`default_nettype wire

// *** adcsc_defines.svh ***
// Purpose: Constants for the ADC sequencing control block
// Assumes: 8-bit special function register bus, 10 MHz master clock
// Notes: Bit positions and reset values of both control registers
// Notes on behaviour
// - Two-bit power mode selects four power states
// - Full off, or reference kept on when idle
// - ADC clock from master clock, code-selected divider
// - Conversion takes seventeen ADC clocks
// - Acquisition lasts 1, 2, 4 or 8 clocks
// - Timer overflow trigger starts on second overflow
// - External active-low pulse starts a conversion
// - Done flag set on single or DMA completion
// - Done flag cleared when interrupt vectors
// - DMA enable bit starts configured DMA mode
// - Continuous bit restarts after each conversion
// - Single bit starts one cycle, self-clears
// - Channel sampled from select field at start
// - DMA mode takes channel from memory identifier
// - Codes 0-7 inputs, 8 temperature, F stop
// - Result carries channel in top nibble
// - Busy asserted throughout conversion cycle
`ifndef ADCSC_DEFINES_SVH
`define ADCSC_DEFINES_SVH
`define ADCSC_ADDR_CHAN_CTRL 8'hd8
`define ADCSC_ADDR_TIME_CTRL 8'hef
`define ADCSC_RST_CHAN_CTRL 8'h00
`define ADCSC_RST_TIME_CTRL 8'h20
`define ADCSC_BIT_DONE 7
`define ADCSC_BIT_DMA 6
`define ADCSC_BIT_CONT 5
`define ADCSC_BIT_SINGLE 4
`define ADCSC_BIT_PM_HI 7
`define ADCSC_BIT_PM_LO 6
`define ADCSC_BIT_CK_HI 5
`define ADCSC_BIT_CK_LO 4
`define ADCSC_BIT_AQ_HI 3
`define ADCSC_BIT_AQ_LO 2
`define ADCSC_BIT_T2 1
`define ADCSC_BIT_EXT 0
`define ADCSC_CONV_CLKS 5'h11
`define ADCSC_PM_OFF 2'h0
`define ADCSC_PM_NORMAL 2'h1
`define ADCSC_PM_OFF_IDLE 2'h2
`define ADCSC_PM_STBY_IDLE 2'h3
`define ADCSC_CH_TEMP 4'h8
`define ADCSC_CH_STOP 4'hf
`define ADCSC_CH_MAX_INPUT 4'h7
`define ADCSC_BIT_CH_HI 3
`define ADCSC_BIT_CH_LO 0
`define ADCSC_ACQ_CLKS_0 5'h01
`define ADCSC_ACQ_CLKS_1 5'h02
`define ADCSC_ACQ_CLKS_2 5'h04
`define ADCSC_ACQ_CLKS_3 5'h08
`define ADCSC_DIV_LAST_1 3'h0
`define ADCSC_DIV_LAST_2 3'h1
`define ADCSC_DIV_LAST_4 3'h3
`define ADCSC_DIV_LAST_8 3'h7
`endif

// *** adcsc_pkg.sv ***
// Purpose: Types for the ADC sequencing control block
// Assumes: Included constants header
// Notes: State enum and state struct
package adcsc_pkg;
	typedef enum logic [1:0] {ADCSC_IDLE, ADCSC_ACQ, ADCSC_CONV} adcsc_state_e;
	typedef struct packed {
		logic [7:0] chan_ctrl;
		logic [7:0] time_ctrl;
		logic [7:0] rdata;
		adcsc_state_e st;
		logic [2:0] div_cnt;
		logic [4:0] step_cnt;
		logic [3:0] conv_ch;
		logic conv_dma;
		logic t2_seen;
		logic ext_prev;
		logic dma_prev;
		logic busy;
		logic conv_go;
		logic result_valid;
		logic [3:0] result_ch;
		logic dma_start;
		logic ref_pwr;
		logic core_pwr;
		logic track;
		logic [3:0] mux_ch;
		logic adc_clk_en;
	} adcsc_state_s;
endpackage

// *** tb_adc_sequencing_control.sv ***
// Purpose: Self-checking bench for the ADC sequencing control
// Assumes: ce held high; SFR reads answer the cycle after the strobe
// Notes: Divided spans allow one ADC clock of phase slack
`timescale 1ns/1ps
`default_nettype none
module tb_adc_sequencing_control;
	logic clk = 0, srst = 1, ce = 1, sfr_wr = 0, sfr_rd = 0, timer_overflow = 0;
	logic dma_block_done = 0, ext_go = 0, ack_go = 0, pin_n, irq_vector_ack;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
	logic [3:0] dma_channel_id = 4'h6, mux_channel, result_channel;
	logic dma_start, busy, track_hold, adc_clk_en, ref_power_on, core_power_on, result_valid;
	int err_count = 0, n_tests = 0, n, i, e, dd;
	always #50 clk = ~clk;
	adcsc_core_model adcsc_core_model_inst (.clk(clk), .ext_go(ext_go), .ack_go(ack_go),
		.pin_n(pin_n), .irq_vector_ack(irq_vector_ack));
	adcsc_control adcsc_control_inst (.clk(clk), .srst(srst), .ce(ce), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.timer_overflow(timer_overflow), .convert_start_pin_n(pin_n),
		.irq_vector_ack(irq_vector_ack), .dma_block_done(dma_block_done),
		.dma_channel_id(dma_channel_id), .dma_start(dma_start), .busy(busy),
		.track_hold(track_hold), .mux_channel(mux_channel), .adc_clk_en(adc_clk_en),
		.ref_power_on(ref_power_on), .core_power_on(core_power_on),
		.result_valid(result_valid), .result_channel(result_channel));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1;
		@(posedge clk);
		#1;
		sfr_wr = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string m);
		@(posedge clk);
		#1;
		sfr_addr = a;
		sfr_rd = 1;
		@(posedge clk);
		#1;
		sfr_rd = 0;
		chk(sfr_rdata, exp, m);
	endtask
	// One-cycle pulse: 0 overflow, 1 pin request, 2 vector ack, 3 block done
	task automatic pulse(input int w);
		@(posedge clk);
		#1;
		case (w)
			0: timer_overflow = 1;
			1: ext_go = 1;
			2: ack_go = 1;
			default: dma_block_done = 1;
		endcase
		@(posedge clk);
		#1;
		timer_overflow = 0;
		ext_go = 0;
		ack_go = 0;
		dma_block_done = 0;
	endtask
	// Waits a bounded time for busy, then counts its cycles
	task automatic meas(output int k);
		int t;
		k = 0;
		t = 0;
		while (busy !== 1'b1 && t < 20)
		begin
			@(posedge clk);
			#1;
			t++;
		end
		while (busy === 1'b1 && k < 600)
		begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		#1;
		srst = 0;
		rd(8'hd8, 8'h00, "chan reset");
		rd(8'hef, 8'h20, "time reset");
		rd(8'h5a, 8'h00, "unmapped");
		$display("test reset done");
		for (i = 0; i < 4; i++)
		begin
			dd = 1 << i;
			e = (dd + 17) * dd;
			wr(8'hef, 8'h40 | 8'(i << 4) | 8'(i << 2));
			wr(8'hd8, 8'h13);
			meas(n);
			chk(8'(n >= e - dd && n <= e + dd), 8'h01, "busy span");
			chk(8'(result_valid), 8'h01, "result pulse");
			chk({4'h0, result_channel}, 8'h03, "result chan");
			rd(8'hd8, 8'h83, "done set single clear");
			pulse(2);
			rd(8'hd8, 8'h03, "done cleared");
		end
		$display("test single done");
		wr(8'hef, 8'h00);
		@(posedge clk);
		#1;
		chk({6'h0, ref_power_on, core_power_on}, 8'h00, "full off");
		wr(8'hd8, 8'h10);
		meas(n);
		chk(8'(n), 8'h00, "no start when off");
		wr(8'hd8, 8'h00);
		wr(8'hef, 8'h80);
		@(posedge clk);
		#1;
		chk({6'h0, ref_power_on, core_power_on}, 8'h02, "idle off ref on");
		wr(8'hef, 8'hc0);
		@(posedge clk);
		#1;
		chk({6'h0, ref_power_on, core_power_on}, 8'h02, "standby idle");
		wr(8'hef, 8'h40);
		@(posedge clk);
		#1;
		chk({7'h0, core_power_on}, 8'h01, "normal on");
		$display("test power done");
		wr(8'hef, 8'h4c);
		wr(8'hd8, 8'h18);
		@(posedge clk);
		#1;
		chk({3'h0, track_hold, mux_channel}, 8'h18, "track temp chan");
		chk({7'h0, adc_clk_en}, 8'h01, "adc clock on");
		repeat (8) @(posedge clk);
		#1;
		chk({7'h0, track_hold}, 8'h00, "hold after acquisition");
		meas(n);
		chk(8'(n), 8'h11, "conversion clocks");
		chk({7'h0, adc_clk_en}, 8'h00, "adc clock off");
		chk({4'h0, result_channel}, 8'h08, "temp result chan");
		$display("test track done");
		wr(8'hef, 8'h42);
		pulse(0);
		repeat (3) @(posedge clk);
		#1;
		chk({7'h0, busy}, 8'h00, "first overflow");
		pulse(0);
		meas(n);
		chk(8'(n), 8'h12, "second overflow");
		$display("test timer done");
		wr(8'hef, 8'h41);
		pulse(1);
		fork
			meas(n);
			begin
				repeat (5) @(posedge clk);
				pulse(1);
			end
		join
		chk(8'(n), 8'h12, "pin start no restart");
		$display("test pin done");
		wr(8'hef, 8'h40);
		wr(8'hd8, 8'h25);
		meas(n);
		meas(n);
		chk(8'(n), 8'h12, "auto restart");
		chk({4'h0, result_channel}, 8'h05, "cont chan");
		wr(8'hd8, 8'h00);
		meas(n);
		$display("test continuous done");
		wr(8'hd8, 8'h40);
		meas(n);
		chk({7'h0, dma_start}, 8'h01, "dma running");
		chk({4'h0, result_channel}, 8'h06, "dma chan");
		pulse(3);
		meas(n);
		rd(8'hd8, 8'h80, "dma done flag");
		dma_channel_id = 4'hf;
		wr(8'hd8, 8'h40);
		meas(n);
		chk({7'h0, dma_start}, 8'h00, "dma stop marker");
		chk(8'(n), 8'h00, "no conversion on stop");
		$display("test dma done");
		results();
	end
	initial
	begin
		#3000000;
		err_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		results();
	end
endmodule
`default_nettype wire
